// *** src/cic_slave.sv ***
`timescale 1ns/1ns
`default_nettype none

module cic_slave (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// Bus pins; the data line is open drain.
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	// Straps.
	input  wire logic             addr_sel,
	input  wire logic             mode_i2c,
	// Register write toward the codec core.
	output cic_pkg::cic_wr_t      reg_wr,
	// Port enabled as latched at reset.
	output logic                  port_on
);

	// Whole state of the port.
	typedef struct packed {
		cic_pkg::cic_phase_t phase;
		cic_pkg::cic_phase_t after_ack;
		logic [7:0]          shift;
		logic [3:0]          bits;
		logic [7:0]          index;
		logic                ack;
		logic                strap_done;
		logic                enable;
		logic                addr_bit;
		cic_pkg::cic_wr_t    wr;
		logic                scl_d;
		logic                sda_d;
	} cic_state_t;

	cic_state_t st;       // Registered state.
	cic_state_t next_st;  // Next state.
	logic [1:0] lines;    // Synchronised scl and sda.
	logic       scl;      // Settled clock level.
	logic       sda;      // Settled data level.
	logic       scl_rise; // Clock rising edge.
	logic       scl_fall; // Clock falling edge.
	logic       start_c;  // Start or repeated start.
	logic       stop_c;   // Stop condition.
	logic [7:0] byte_in;  // Byte as completed by this rising edge.
	logic [1:0] straps;   // Synchronised addr_sel and mode_i2c.

	// Pins pass two flops before any decode.
	cic_sync u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.pin_in  ({scl_in, sda_in}),
		.pin_out (lines)
	);

	// The straps are pins too, so they pass two flops as well.
	// This pair is kept out of reset so that it already shows the pin
	// level at the first edge after reset, when the port latches it.
	cic_sync u_strap_sync (
		.sys_clk (sys_clk),
		.sys_rst (1'b0),
		.pin_in  ({addr_sel, mode_i2c}),
		.pin_out (straps)
	);

	assign scl      = lines[1];
	assign sda      = lines[0];
	// At 250 MHz both modes are sampled many times per bit.
	// slave sampling
	assign scl_rise = scl & ~st.scl_d;
	assign scl_fall = ~scl & st.scl_d;
	assign start_c  = scl & st.scl_d & st.sda_d & ~sda;
	assign stop_c   = scl & st.scl_d & ~st.sda_d & sda;
	assign byte_in  = {st.shift[6:0], sda};

	// Next-state logic of the receive sequence.
	always_comb begin
		next_st          = st;
		next_st.scl_d    = scl;
		next_st.sda_d    = sda;
		next_st.wr.valid = 1'b0;
		if (!st.strap_done) begin
			next_st.strap_done = 1'b1;
			next_st.enable     = straps[0];
			next_st.addr_bit   = straps[1];
		end
		if (!st.enable) begin
			next_st.phase = cic_pkg::CIC_IDLE;
		end else if (stop_c) begin
			next_st.phase = cic_pkg::CIC_IDLE;
			next_st.ack   = 1'b0;
		end else if (start_c) begin
			next_st.phase = cic_pkg::CIC_ADDR;
			next_st.bits  = 4'h0;
			next_st.ack   = 1'b0;
		end else begin
			unique case (st.phase)
				cic_pkg::CIC_IDLE, cic_pkg::CIC_IGNORE: begin
					next_st.phase = st.phase;
				end
				cic_pkg::CIC_ADDR, cic_pkg::CIC_INDEX,
				cic_pkg::CIC_DATA: begin
					if (scl_rise) begin
						next_st.shift = byte_in;
						next_st.bits  = st.bits + 4'h1;
					end
					if (scl_fall && st.bits == cic_pkg::BYTE_BITS) begin
						next_st.bits  = 4'h0;
						next_st.phase = cic_pkg::CIC_ACK;
						next_st.ack   = 1'b0;
						if (st.phase == cic_pkg::CIC_ADDR) begin
							if (st.shift[7:2] == cic_pkg::ADDR_FIXED &&
							    st.shift[1] == st.addr_bit &&
							    !st.shift[0]) begin
								next_st.ack       = 1'b1;
								next_st.after_ack = cic_pkg::CIC_INDEX;
							end else begin
								next_st.phase = cic_pkg::CIC_IGNORE;
							end
						end else if (st.phase == cic_pkg::CIC_INDEX) begin
							next_st.index = st.shift;
							next_st.ack = st.shift >= cic_pkg::REG_FIRST &&
							              st.shift < cic_pkg::REG_WRAP;
							next_st.after_ack = cic_pkg::CIC_DATA;
						end else begin
							next_st.ack = st.index >= cic_pkg::REG_FIRST &&
							              st.index < cic_pkg::REG_WRAP;
							next_st.after_ack = cic_pkg::CIC_DATA;
							if (next_st.ack) begin
								next_st.wr.valid = 1'b1;
								next_st.wr.index = st.index;
								next_st.wr.data  = st.shift;
								if (st.index + 8'h01 == cic_pkg::REG_WRAP)
									next_st.index = cic_pkg::REG_FIRST;
								else
									next_st.index = st.index + 8'h01;
							end
						end
					end
				end
				cic_pkg::CIC_ACK: begin
					// Release the line after the ninth clock falls.
					if (scl_fall) begin
						next_st.ack   = 1'b0;
						next_st.phase = st.after_ack;
					end
				end
				default: next_st.phase = cic_pkg::CIC_IDLE;
			endcase
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st            <= '0;
			st.phase      <= cic_pkg::CIC_IDLE;
			st.after_ack  <= cic_pkg::CIC_IDLE;
			st.scl_d      <= 1'b1;
			st.sda_d      <= 1'b1;
			st.index      <= cic_pkg::BYTE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = st.ack;
	assign reg_wr  = st.wr;
	assign port_on = st.enable;

	// Assertions.
	a_ack_window: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		sda_oe |-> st.phase == cic_pkg::CIC_ACK)
		else $error("ack driven outside ack slot");
	// A master may name an undefined index, so only the index left
	// behind by a write is held away from the wrap value.
	a_wrap_index: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr.valid |-> st.index != cic_pkg::REG_WRAP)
		else $error("index reached wrap value");
	a_write_range: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr.valid |-> reg_wr.index >= cic_pkg::REG_FIRST &&
		                 reg_wr.index < cic_pkg::REG_WRAP)
		else $error("write to undefined index");
	a_index_step: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr.valid |-> st.index == ((reg_wr.index == 8'h49) ?
		                 cic_pkg::REG_FIRST : reg_wr.index + 8'h01))
		else $error("index did not advance");
	a_strap_hold: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		$past(st.strap_done) |-> $stable(port_on))
		else $error("mode changed after reset");
	a_off_silent: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!port_on |-> !sda_oe && !reg_wr.valid)
		else $error("disabled port active");
	a_ignore_quiet: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		st.phase == cic_pkg::CIC_IGNORE |=> !sda_oe)
		else $error("ack in ignored transfer");
	a_ack_ends: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(sda_oe) |-> $past(scl_fall) || $past(stop_c) ||
		                  $past(start_c))
		else $error("ack released off edge");
	c_write: cover property (@(posedge sys_clk) reg_wr.valid);
	c_wrap: cover property (@(posedge sys_clk)
		reg_wr.valid && reg_wr.index == 8'h49);
	c_ignore: cover property (@(posedge sys_clk)
		st.phase == cic_pkg::CIC_IGNORE);

endmodule

`default_nettype wire

// *** src/cic_pkg.sv ***
package cic_pkg;

	// Fixed upper six bits of the seven-bit slave address.
	localparam logic [5:0] ADDR_FIXED = 6'h23;
	// First and one-past-last register index of the control window.
	localparam logic [7:0] REG_FIRST  = 8'h40;
	localparam logic [7:0] REG_WRAP   = 8'h4a;
	// Bits per byte before the acknowledge slot.
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	// Reset value of the index; the shift register resets to zero with the rest of the state.
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Fastest bus clocks: standard and fast mode, in kHz.
	localparam int SCL_STD_KHZ  = 100;
	localparam int SCL_FAST_KHZ = 400;
	// System clock rate in MHz.
	localparam int SYS_MHZ      = 250;
	// Cycles in the shortest fast-mode clock high time (0.6 us, rounded up).
	localparam int T_HI_NS      = 600;
	localparam int T_HI_CYC     = (T_HI_NS * SYS_MHZ + 999) / 1000;

	// Phase of the receive sequence.
	typedef enum logic [2:0] {
		CIC_IDLE,
		CIC_ADDR,
		CIC_INDEX,
		CIC_DATA,
		CIC_ACK,
		CIC_IGNORE
	} cic_phase_t;

	// A register write handed to the codec core.
	typedef struct packed {
		logic       valid;
		logic [7:0] index;
		logic [7:0] data;
	} cic_wr_t;

	// Synchronised and delayed bus levels.
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_d;
		logic sda_d;
	} cic_lines_t;

endpackage

// *** src/cic_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for the bus pins.
module cic_sync (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Raw pins in, settled levels out.
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_out
);

	// Stage one is read only by stage two.
	logic [1:0] meta;

	// Idle bus level is high, so reset both stages high.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta    <= 2'h3;
			pin_out <= 2'h3;
		end else begin
			meta    <= pin_in;
			pin_out <= meta;
		end
	end

endmodule

`default_nettype wire

// *** sim/cic_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Bus master; idles with the clock high and data released.
module cic_master_model #(
	parameter int LOW_CYC  = 400,
	parameter int HIGH_CYC = 226
) (
	// Clock and resolved data level.
	input  wire logic sys_clk,
	input  wire logic sda_line,
	// Driven lines.
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Data moves mid low phase, so it never races the clock edges.
	task automatic bit_io(input logic b, output logic seen);
		repeat (LOW_CYC / 2) @(posedge sys_clk);
		sda_low <= !b;
		repeat (LOW_CYC / 2) @(posedge sys_clk);
		scl <= 1'b1;
		repeat (HIGH_CYC / 2) @(posedge sys_clk);
		seen = sda_line;
		repeat (HIGH_CYC / 2) @(posedge sys_clk);
		scl <= 1'b0;
	endtask

	task automatic cond(input logic first, input logic last);
		repeat (LOW_CYC / 2) @(posedge sys_clk);
		sda_low <= !first;
		repeat (LOW_CYC / 2) @(posedge sys_clk);
		scl <= 1'b1;
		repeat (HIGH_CYC) @(posedge sys_clk);
		sda_low <= !last;
		repeat (HIGH_CYC) @(posedge sys_clk);
		scl <= last;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask
endmodule

`default_nettype wire

// *** sim/test_codec_i2c_control_slave.sv ***
`timescale 1ns/1ns
`default_nettype none

// Bench for the two-wire control slave.
module test_codec_i2c_control_slave;
	logic             sys_clk = 1'b0;   // System clock.
	logic             sys_rst = 1'b1;   // Synchronous reset.
	logic             addr_sel = 1'b0;  // Address strap.
	logic             mode_i2c = 1'b1;  // Mode strap.
	logic             scl;              // Bus clock.
	logic             sda_low;          // Master pulls data low.
	logic             sda_out;          // Slave data value.
	logic             sda_oe;           // Slave pull enable.
	logic             port_on;          // Latched mode.
	wire logic        sda_line;         // Pulled-up data wire.
	cic_pkg::cic_wr_t reg_wr;           // Write strobe out.
	logic [15:0]      wr_q[$];          // Seen index and data.
	int               miscompares = 0;
	int               total_checks = 0;
	int               cycles = 0;

	// Either party may pull low; otherwise the pull-up wins.
	assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

	always #2 sys_clk = ~sys_clk;

	cic_slave i_cic_slave (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.scl_in   (scl),
		.sda_in   (sda_line),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.addr_sel (addr_sel),
		.mode_i2c (mode_i2c),
		.reg_wr   (reg_wr),
		.port_on  (port_on)
	);

	cic_master_model i_cic_master_model (
		.sys_clk  (sys_clk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_low  (sda_low)
	);

	// Capture writes and cut a hang short.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (reg_wr.valid === 1'b1) begin
			wr_q.push_back({reg_wr.index, reg_wr.data});
		end
		if (cycles == 85000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Straps are set while reset is held.
	task automatic do_reset(input logic sel, input logic mode);
		addr_sel <= sel;
		mode_i2c <= mode;
		sys_rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		wr_q.delete();
	endtask

	// One byte and its acknowledge slot.
	task automatic put(input logic [7:0] b, input logic exp_ack);
		logic ack;
		i_cic_master_model.send_byte(b, ack);
		check("ack", {15'h0000, ack}, {15'h0000, exp_ack});
	endtask

	// Burst across the end of the window; mode pin dropped.
	task automatic sc_wrap();
		do_reset(1'b0, 1'b1);
		mode_i2c <= 1'b0;
		i_cic_master_model.cond(1'b1, 1'b0);
		put(8'h8c, 1'b1);
		put(8'h48, 1'b1);
		put(8'ha1, 1'b1);
		put(8'hb2, 1'b1);
		put(8'hc3, 1'b1);
		i_cic_master_model.cond(1'b0, 1'b1);
		check("wr0", wr_q[0], 16'h48a1);
		check("wr1", wr_q[1], 16'h49b2);
		check("wr2", wr_q[2], 16'h40c3);
		check("writes", 16'(wr_q.size()), 16'h0003);
		check("port_on", {15'h0000, port_on}, 16'h0001);
	endtask

	// Other address, read bit, then an undefined index.
	task automatic sc_sel();
		do_reset(1'b1, 1'b1);
		i_cic_master_model.cond(1'b1, 1'b0);
		put(8'h8c, 1'b0);
		i_cic_master_model.cond(1'b1, 1'b0);
		put(8'h8f, 1'b0);
		i_cic_master_model.cond(1'b1, 1'b0);
		put(8'h8e, 1'b1);
		put(8'h4a, 1'b0);
		put(8'h11, 1'b0);
		i_cic_master_model.cond(1'b0, 1'b1);
		check("writes", 16'(wr_q.size()), 16'h0000);
	endtask

	// Port held off by the mode strap.
	task automatic sc_off();
		do_reset(1'b1, 1'b0);
		i_cic_master_model.cond(1'b1, 1'b0);
		put(8'h8e, 1'b0);
		i_cic_master_model.cond(1'b0, 1'b1);
		check("port_on", {15'h0000, port_on}, 16'h0000);
	endtask

	initial begin
		@(posedge sys_clk);
		sc_wrap();
		sc_sel();
		sc_off();
		give_verdict();
	end
endmodule

`default_nettype wire
